// >>> core/cab_irq_regs.svh
`ifndef CAB_IRQ_REGS_SVH
`define CAB_IRQ_REGS_SVH

// =============================================================
// Register indices; byte address is four times the index.
`define CAB_IDX_CI_STATUS 12'hb40
`define CAB_IDX_CI_ENABLE 12'hb41
`define CAB_IDX_BOC_STATUS 12'hb70
`define CAB_IDX_BOC_ENABLE 12'hb71

// =============================================================
// Field positions.
`define CAB_BIT_AIS_CHANGE 1
`define CAB_BIT_RAI_CHANGE 0
`define CAB_BIT_AIS_STATE 5
`define CAB_BIT_RAI_STATE 4
`define CAB_BIT_MATCH_THIRD 7
`define CAB_BIT_MATCH_SECOND 6

// =============================================================
// Reset values.
`define CAB_RST_CI_ENABLE 2'h0
`define CAB_RST_BOC_ENABLE 8'h00
`define CAB_RST_PRDATA 32'h0000_0000

`endif

// >>> core/cab_pkg.sv
package cab_pkg;
   typedef enum logic {
      apb_idle,
      apb_access
   } cab_apb_state_t;
   typedef logic [7:0] cab_byte_t;
   typedef logic [1:0] cab_ci_bits_t;
endpackage

// >>> core/cab_event_flag.sv
`timescale 1ns/1ps
`default_nettype none
module cab_event_flag #(
   parameter int WIDTH = 1
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_set,
   input wire logic [WIDTH-1:0] i_clear,
   output logic [WIDTH-1:0] o_flag
);
   logic [WIDTH-1:0] flag;
   logic [WIDTH-1:0] next_flag;

   // A set in the same cycle as a clear keeps the flag.
   always_comb begin
      next_flag = i_set | (flag & ~i_clear);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         flag <= '0;
      end else begin
         flag <= next_flag;
      end
   end

   assign o_flag = flag;

   a_set_wins_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (|(i_set & i_clear)) |=> ((o_flag & $past(i_set & i_clear)) == $past(i_set & i_clear)))
      else $error("Event lost against a coincident clear.");
endmodule
`default_nettype wire

// >>> core/cab_change_det.sv
`timescale 1ns/1ps
`default_nettype none
module cab_change_det (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_state,
   output logic o_change
);
   logic prev;
   logic next_prev;

   always_comb begin
      next_prev = i_state;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         prev <= 1'b0;
      end else begin
         prev <= next_prev;
      end
   end

   // Either direction of the detector state counts as a change.
   assign o_change = i_state ^ prev;
endmodule
`default_nettype wire

// >>> core/cab_ci_alarm_boc_irq.sv
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "cab_irq_regs.svh"
module cab_ci_alarm_boc_irq
   import cab_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [15:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_ais_ci_state,
   input wire logic i_rai_ci_state,
   input wire logic i_fdl_match_third,
   input wire logic i_fdl_match_second,
   input wire logic i_code_cleared,
   input wire logic i_rx_link_abort,
   input wire logic i_rx_link_full,
   input wire logic i_tx_link_empty,
   input wire logic i_fdl_match_first,
   input wire logic i_code_change,
   output logic o_irq
);
   // =============================================================
   // Address decode.
   localparam logic [15:0] ADDR_CI_STATUS = {2'h0, `CAB_IDX_CI_STATUS, 2'h0};
   localparam logic [15:0] ADDR_CI_ENABLE = {2'h0, `CAB_IDX_CI_ENABLE, 2'h0};
   localparam logic [15:0] ADDR_BOC_STATUS = {2'h0, `CAB_IDX_BOC_STATUS, 2'h0};
   localparam logic [15:0] ADDR_BOC_ENABLE = {2'h0, `CAB_IDX_BOC_ENABLE, 2'h0};

   cab_apb_state_t state;
   cab_apb_state_t next_state;
   logic [31:0] prdata;
   logic [31:0] next_prdata;
   logic pready;
   logic next_pready;
   logic pslverr;
   logic next_pslverr;
   logic irq;
   logic next_irq;
   cab_ci_bits_t ci_en;
   cab_ci_bits_t next_ci_en;
   cab_byte_t boc_en;
   cab_byte_t next_boc_en;

   logic setup;
   logic done;
   logic hit_ci_status;
   logic hit_ci_enable;
   logic hit_boc_status;
   logic hit_boc_enable;
   logic hit;
   logic ais_change;
   logic rai_change;
   cab_ci_bits_t ci_set;
   cab_ci_bits_t ci_clear;
   cab_ci_bits_t ci_flags;
   cab_byte_t boc_set;
   cab_byte_t boc_clear;
   cab_byte_t boc_flags;
   cab_byte_t ci_status_word;
   cab_byte_t rd_byte;

   always_comb begin
      setup = i_psel & ~i_penable;
      done = i_psel & i_penable & pready;
      hit_ci_status = (i_paddr == ADDR_CI_STATUS);
      hit_ci_enable = (i_paddr == ADDR_CI_ENABLE);
      hit_boc_status = (i_paddr == ADDR_BOC_STATUS);
      hit_boc_enable = (i_paddr == ADDR_BOC_ENABLE);
      hit = hit_ci_status | hit_ci_enable | hit_boc_status | hit_boc_enable;
   end

   // =============================================================
   // Event sources.
   cab_change_det u_ais_det (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_state(i_ais_ci_state),
      .o_change(ais_change)
   );

   cab_change_det u_rai_det (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_state(i_rai_ci_state),
      .o_change(rai_change)
   );

   always_comb begin
      ci_set = 2'h0;
      ci_set[`CAB_BIT_AIS_CHANGE] = ais_change;
      ci_set[`CAB_BIT_RAI_CHANGE] = rai_change;
      boc_set = {i_fdl_match_third,
                 i_fdl_match_second,
                 i_code_cleared,
                 i_rx_link_abort,
                 i_rx_link_full,
                 i_tx_link_empty,
                 i_fdl_match_first,
                 i_code_change};
   end

   // =============================================================
   // Status flags.
   // A read clears only the bits it returned, so an event arriving after the
   // read data were captured survives. A write clears the bits written as 1.
   always_comb begin
      ci_clear = 2'h0;
      boc_clear = 8'h00;
      if (done && hit_ci_status) begin
         ci_clear = i_pwrite ? i_pwdata[1:0] : prdata[1:0];
      end
      if (done && hit_boc_status) begin
         boc_clear = i_pwrite ? i_pwdata[7:0] : prdata[7:0];
      end
   end

   cab_event_flag #(
      .WIDTH(2)
   ) u_ci_flags (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_set(ci_set),
      .i_clear(ci_clear),
      .o_flag(ci_flags)
   );

   cab_event_flag #(
      .WIDTH(8)
   ) u_boc_flags (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_set(boc_set),
      .i_clear(boc_clear),
      .o_flag(boc_flags)
   );

   // =============================================================
   // Bus slave and enables.
   always_comb begin
      ci_status_word = 8'h00;
      ci_status_word[`CAB_BIT_AIS_STATE] = i_ais_ci_state;
      ci_status_word[`CAB_BIT_RAI_STATE] = i_rai_ci_state;
      ci_status_word[1:0] = ci_flags;
      rd_byte = 8'h00;
      if (hit_ci_status) begin
         rd_byte = ci_status_word;
      end else if (hit_ci_enable) begin
         rd_byte = {6'h00, ci_en};
      end else if (hit_boc_status) begin
         rd_byte = boc_flags;
      end else if (hit_boc_enable) begin
         rd_byte = boc_en;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         apb_idle: begin
            if (setup) begin
               next_state = apb_access;
            end
         end
         apb_access: begin
            if (done) begin
               next_state = apb_idle;
            end
         end
         default: begin
            next_state = apb_idle;
         end
      endcase
      next_pready = setup;
      next_pslverr = setup & ~hit;
      next_prdata = prdata;
      if (setup) begin
         next_prdata = i_pwrite ? `CAB_RST_PRDATA : {24'h00_0000, rd_byte};
      end
      next_ci_en = ci_en;
      next_boc_en = boc_en;
      if (done && i_pwrite && hit_ci_enable) begin
         next_ci_en = i_pwdata[1:0];
      end
      if (done && i_pwrite && hit_boc_enable) begin
         next_boc_en = i_pwdata[7:0];
      end
      next_irq = (|(ci_flags & ci_en)) | (|(boc_flags & boc_en));
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         state <= apb_idle;
         prdata <= `CAB_RST_PRDATA;
         pready <= 1'b0;
         pslverr <= 1'b0;
         ci_en <= `CAB_RST_CI_ENABLE;
         boc_en <= `CAB_RST_BOC_ENABLE;
         irq <= 1'b0;
      end else begin
         state <= next_state;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         ci_en <= next_ci_en;
         boc_en <= next_boc_en;
         irq <= next_irq;
      end
   end

   assign o_prdata = prdata;
   assign o_pready = pready;
   assign o_pslverr = pslverr;
   assign o_irq = irq;

   // =============================================================
   // Assertions.
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   a_pready_after_setup: assert property (setup |=> o_pready)
      else $error("Ready did not follow the setup cycle.");

   a_unmapped_error: assert property (setup && !hit |=> o_pslverr && o_pready)
      else $error("Unmapped access not answered with an error.");

   a_ais_change_sets: assert property ($changed(i_ais_ci_state) |=> ci_flags[1])
      else $error("AIS-CI transition did not set its flag.");

   a_rai_change_sets: assert property ($changed(i_rai_ci_state) |=> ci_flags[0])
      else $error("RAI-CI transition did not set its flag.");

   a_ais_read_clears: assert property (done && !i_pwrite && hit_ci_status && prdata[1]
      && !ais_change |=> !ci_flags[1])
      else $error("AIS-CI flag survived its read.");

   a_rai_write_clears: assert property (done && i_pwrite && hit_ci_status && i_pwdata[0]
      && !rai_change |=> !ci_flags[0])
      else $error("RAI-CI flag survived its write.");

   a_ais_enable_write: assert property (done && i_pwrite && hit_ci_enable
      |=> ci_en[1] == $past(i_pwdata[1]))
      else $error("AIS-CI enable did not take the written value.");

   a_rai_enable_write: assert property (done && i_pwrite && hit_ci_enable
      |=> ci_en[0] == $past(i_pwdata[0]))
      else $error("RAI-CI enable did not take the written value.");

   a_boc_read_layout: assert property (setup && !i_pwrite && hit_boc_status
      |=> o_prdata == {24'h00_0000, $past(boc_flags)})
      else $error("Code status read data do not match the flags.");

   a_match_third_sets: assert property (i_fdl_match_third |=> boc_flags[7])
      else $error("Third match did not set bit 7.");

   a_match_second_sets: assert property (i_fdl_match_second |=> boc_flags[6])
      else $error("Second match did not set bit 6.");

   a_irq_gating: assert property ((|(ci_flags & ci_en)) || (|(boc_flags & boc_en))
      |=> o_irq)
      else $error("Enabled flag did not raise the interrupt.");

   a_irq_quiet: assert property (!(|(ci_flags & ci_en)) && !(|(boc_flags & boc_en))
      |=> !o_irq)
      else $error("Interrupt high with no enabled flag.");

   a_state_in_status: assert property (setup && !i_pwrite && hit_ci_status
      |=> o_prdata[5] == $past(i_ais_ci_state))
      else $error("AIS-CI state missing from status read.");

   a_ais_write_clears: assert property (done && i_pwrite && hit_ci_status && i_pwdata[1]
      && !ais_change |=> !ci_flags[1])
      else $error("AIS-CI flag survived a one written to it.");

   a_rai_read_clears: assert property (done && !i_pwrite && hit_ci_status && prdata[0]
      && !rai_change |=> !ci_flags[0])
      else $error("RAI-CI flag survived its read.");

   a_boc_read_clears: assert property (done && !i_pwrite && hit_boc_status
      |=> ((boc_flags & $past(prdata[7:0] & ~boc_set)) == 8'h00))
      else $error("Code status bits survived their read.");

   a_boc_event_sets: assert property ((|boc_set)
      |=> ((boc_flags & $past(boc_set)) == $past(boc_set)))
      else $error("Code event did not set its flag.");

   a_hole_write_ignored: assert property (done && i_pwrite && !hit
      |=> (ci_en == $past(ci_en)) && (boc_en == $past(boc_en)))
      else $error("Unmapped write changed an enable.");

   a_pready_single: assert property (o_pready |=> !o_pready)
      else $error("Ready stood longer than one cycle.");

   c_ci_read_flag: cover property (done && !i_pwrite && hit_ci_status && prdata[1]);
   c_irq_rise: cover property (!o_irq ##1 o_irq);
   c_event_on_clear: cover property (done && hit_boc_status && |(boc_clear & boc_set));
   c_match_third_irq: cover property (boc_flags[7] && boc_en[7] ##1 o_irq);
endmodule
`default_nettype wire

// >>> bench/cab_ci_alarm_boc_irq_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cab_irq_regs.svh"
module cab_ci_alarm_boc_irq_tb
   import cab_pkg::*;
;
   localparam logic [15:0] A_CI_ST = {2'b00, `CAB_IDX_CI_STATUS, 2'b00};
   localparam logic [15:0] A_CI_EN = {2'b00, `CAB_IDX_CI_ENABLE, 2'b00};
   localparam logic [15:0] A_BOC_ST = {2'b00, `CAB_IDX_BOC_STATUS, 2'b00};
   localparam logic [15:0] A_BOC_EN = {2'b00, `CAB_IDX_BOC_ENABLE, 2'b00};
   localparam logic [15:0] A_HOLE = 16'h2d08;
   localparam int TIMEOUT = 5000;

   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic ais = 1'b0;
   logic rai = 1'b0;
   logic [7:0] ev = 8'h00;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [31:0] rdata;
   logic err;
   int fail_count = 0;
   int check_count = 0;
   int cycles = 0;

   cab_ci_alarm_boc_irq dut (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_psel(psel),
      .i_penable(penable),
      .i_pwrite(pwrite),
      .i_paddr(paddr),
      .i_pwdata(pwdata),
      .o_prdata(prdata),
      .o_pready(pready),
      .o_pslverr(pslverr),
      .i_ais_ci_state(ais),
      .i_rai_ci_state(rai),
      .i_fdl_match_third(ev[7]),
      .i_fdl_match_second(ev[6]),
      .i_code_cleared(ev[5]),
      .i_rx_link_abort(ev[4]),
      .i_rx_link_full(ev[3]),
      .i_tx_link_empty(ev[2]),
      .i_fdl_match_first(ev[1]),
      .i_code_change(ev[0]),
      .o_irq(irq)
   );

   // ============================================================
   // Clock, timeout and verdict.
   initial begin
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   task automatic end_of_test();
      $display("Checks: %0d, mismatches: %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   always @(posedge i_ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == TIMEOUT) begin
         fail_count++;
         $display("MISMATCH at %0t: timeout", $time);
         end_of_test();
      end
   end

   // ============================================================
   // Bus and compare tasks.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, w, got, exp);
      end
   endtask

   // The request is held until pready is sampled high at a rising edge.
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge i_ref_clk);
      penable <= 1'b1;
      @(posedge i_ref_clk);
      while (pready !== 1'b1) begin
         @(posedge i_ref_clk);
      end
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input cab_byte_t e, input string w);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdata, {24'h000000, e}, w);
      chk({31'h0, err}, 32'h0000_0000, w);
   endtask

   task automatic wr(input logic [15:0] a, input cab_byte_t d);
      apb(1'b1, a, {24'h000000, d});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask

   task automatic pulse(input int b);
      @(posedge i_ref_clk);
      ev[b] <= 1'b1;
      @(posedge i_ref_clk);
      ev[b] <= 1'b0;
   endtask

   task automatic irq_is(input logic e);
      @(negedge i_ref_clk);
      chk({31'h0, irq}, {31'h0, e}, "irq");
   endtask

   // ============================================================
   // Test sequence.
   initial begin
      repeat (5) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      rd(A_CI_EN, 8'h00, "ci en rst");
      rd(A_BOC_EN, 8'h00, "code en rst");
      rd(A_BOC_ST, 8'h00, "code st rst");
      rd(A_CI_ST, 8'h00, "ci st rst");
      irq_is(1'b0);
      wr(A_CI_EN, 8'hff);
      rd(A_CI_EN, 8'h03, "ci en rw");
      wr(A_CI_EN, 8'h00);
      for (int b = 0; b < 8; b++) begin
         pulse(b);
         rd(A_BOC_ST, cab_byte_t'(8'h01 << b), "code flag");
         rd(A_BOC_ST, 8'h00, "code read clr");
      end
      @(posedge i_ref_clk);
      ais <= 1'b1;
      cyc(3);
      rd(A_CI_ST, 8'h22, "ais rise");
      rd(A_CI_ST, 8'h20, "ais read clr");
      @(posedge i_ref_clk);
      ais <= 1'b0;
      cyc(3);
      wr(A_CI_ST, 8'h00);
      rd(A_CI_ST, 8'h02, "ais fall");
      @(posedge i_ref_clk);
      rai <= 1'b1;
      cyc(3);
      wr(A_CI_ST, 8'h01);
      rd(A_CI_ST, 8'h10, "rai write clr");
      @(posedge i_ref_clk);
      rai <= 1'b0;
      cyc(3);
      rd(A_CI_ST, 8'h01, "rai fall");
      wr(A_CI_EN, 8'h02);
      @(posedge i_ref_clk);
      rai <= 1'b1;
      cyc(3);
      irq_is(1'b0);
      @(posedge i_ref_clk);
      ais <= 1'b1;
      cyc(3);
      irq_is(1'b1);
      rd(A_CI_ST, 8'h33, "both latched");
      cyc(1);
      irq_is(1'b0);
      wr(A_CI_EN, 8'h01);
      @(posedge i_ref_clk);
      rai <= 1'b0;
      cyc(3);
      irq_is(1'b1);
      wr(A_CI_ST, 8'h03);
      cyc(1);
      irq_is(1'b0);
      wr(A_CI_EN, 8'h00);
      wr(A_BOC_EN, 8'h80);
      rd(A_BOC_EN, 8'h80, "code en rw");
      pulse(6);
      cyc(1);
      irq_is(1'b0);
      pulse(7);
      cyc(1);
      irq_is(1'b1);
      rd(A_BOC_ST, 8'hc0, "match flags");
      cyc(1);
      irq_is(1'b0);
      pulse(7);
      // A new match lands on the edge that commits the clearing read.
      fork
         apb(1'b0, A_BOC_ST, 32'h0000_0000);
         begin
            cyc(2);
            ev[7] <= 1'b1;
            @(posedge i_ref_clk);
            ev[7] <= 1'b0;
         end
      join
      chk(rdata, 32'h0000_0080, "clash read");
      rd(A_BOC_ST, 8'h80, "clash kept");
      rd(A_BOC_ST, 8'h00, "clash cleared");
      pulse(7);
      cyc(1);
      irq_is(1'b1);
      // A second reset in mid-run; the AIS-CI input stays high across it.
      @(posedge i_ref_clk);
      i_rst <= 1'b1;
      cyc(2);
      i_rst <= 1'b0;
      irq_is(1'b0);
      rd(A_BOC_EN, 8'h00, "code en rst2");
      rd(A_BOC_ST, 8'h00, "code st rst2");
      rd(A_CI_ST, 8'h22, "ci st rst2");
      wr(A_HOLE, 8'hff);
      chk({31'h0, err}, 32'h0000_0001, "hole wr error");
      apb(1'b0, A_HOLE, 32'h0000_0000);
      chk({31'h0, err}, 32'h0000_0001, "hole error");
      chk(rdata, 32'h0000_0000, "hole data");
      rd(A_CI_EN, 8'h00, "ci en kept");
      end_of_test();
   end
endmodule
`default_nettype wire
